/* bench/opte_enc_model.sv */
`timescale 1ns/1ps
module opte_enc_model (
  // Clock
  input wire logic clk_in,
  // Encoder tracks
  output logic a_out,
  output logic b_out
);
  initial
  begin
    a_out = 1'b0;
    b_out = 1'b0;
  end

  // Edges far closer than the top encoder rate, so no loss here means none there
  task automatic turn(input int n, input logic bwd);
    repeat (n)
    begin
      @(posedge clk_in);
      b_out <= bwd;
      repeat (6) @(posedge clk_in);
      a_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      a_out <= 1'b0;
    end
  endtask

  task automatic revs(input int r, input logic bwd);
    turn(50 * r, bwd);
  endtask
endmodule

/* bench/opte_top_assertions.sv */
`timescale 1ns/1ps
`include "opte_params.svh"
module opte_top_assertions #(
  parameter logic [39:0] BRIDGE_CYC = 40'd50
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Register port
  input wire logic [`OPTE_ADDR_W-1:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic [31:0] RDATA_OUT,
  // Power and range
  input wire logic MAIN_BAT_IN,
  input wire logic BRIDGE_BAT_IN,
  input wire logic TRANSP_SEEN_IN,
  input wire logic POWER_OFF_OUT,
  input wire logic SHUTDOWN_OUT
);
  logic [39:0] low_cyc;

  // Saturation is not needed: no run keeps the battery out for 2^40 cycles
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN || MAIN_BAT_IN)
      low_cyc <= 40'h0;
    else
      low_cyc <= low_cyc + 40'h1;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_no_power;
    (!MAIN_BAT_IN && !BRIDGE_BAT_IN) [*6];
  endsequence
  sequence s_bad_read;
    RD_IN && (ADDR_IN[1:0] != 2'h0 || ADDR_IN > 8'h24);
  endsequence

  property p_rdata_idle;
    !RD_IN |=> RDATA_OUT == 32'h0;
  endproperty
  property p_unmapped;
    s_bad_read |=> RDATA_OUT == 32'h0;
  endproperty
  property p_off_hold;
    POWER_OFF_OUT |=> POWER_OFF_OUT;
  endproperty
  property p_shut_hold;
    SHUTDOWN_OUT |=> SHUTDOWN_OUT;
  endproperty
  property p_no_bridge;
    s_no_power |=> POWER_OFF_OUT;
  endproperty
  property p_bridge_min;
    $rose(POWER_OFF_OUT) && BRIDGE_BAT_IN |-> low_cyc >= BRIDGE_CYC;
  endproperty
  property p_bridge_max;
    low_cyc == BRIDGE_CYC + 40'd8 |-> POWER_OFF_OUT;
  endproperty
  property p_shut_cause;
    $rose(SHUTDOWN_OUT) |-> !TRANSP_SEEN_IN || POWER_OFF_OUT;
  endproperty

  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read answer");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read gave nonzero data");
  a_off_hold: assert property (p_off_hold)
    else $error("power off dropped");
  a_shut_hold: assert property (p_shut_hold)
    else $error("shutdown dropped");
  a_no_bridge: assert property (p_no_bridge)
    else $error("no power off without any battery");
  a_bridge_min: assert property (p_bridge_min)
    else $error("bridge time cut short");
  a_bridge_max: assert property (p_bridge_max)
    else $error("bridge time overrun");
  a_shut_cause: assert property (p_shut_cause)
    else $error("shutdown without cause");
endmodule

bind opte_top opte_top_assertions #(.BRIDGE_CYC(BRIDGE_CYC)) i_chk (
  .CLK_IN,
  .RST_IN,
  .ADDR_IN,
  .RD_IN,
  .RDATA_OUT,
  .MAIN_BAT_IN,
  .BRIDGE_BAT_IN,
  .TRANSP_SEEN_IN,
  .POWER_OFF_OUT,
  .SHUTDOWN_OUT
);

/* bench/opte_top_test.sv */
`timescale 1ns/1ps
module opte_top_test;
  logic clk, rst, wr_in, rd_in, ksw_cw, ksw_ccw, main_bat, bridge_bat, transp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, exp;
  logic [17:0] fkey_led, fkey;
  logic [1:0] pb, pb_led;
  logic wa, wb, power_off, shutdown, irq, last, card;
  int miscompares, checked, cyc, flips, odd;

  opte_top #(.BRIDGE_CYC(40'd50), .SLOW_HALF_CYC(8), .FAST_HALF_CYC(2)) i_dut (
    .CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_in), .RD_IN(rd_in), .RDATA_OUT(rdata), .FKEY_IN(fkey),
    .KSW_CW_IN(ksw_cw), .KSW_CCW_IN(ksw_ccw), .PB_IN(pb), .WHEEL_A_IN(wa),
    .WHEEL_B_IN(wb), .MAIN_BAT_IN(main_bat), .BRIDGE_BAT_IN(bridge_bat),
    .TRANSP_SEEN_IN(transp), .CARD_IN(card), .FKEY_LED_OUT(fkey_led),
    .PB_LED_OUT(pb_led), .POWER_OFF_OUT(power_off), .SHUTDOWN_OUT(shutdown),
    .IRQ_OUT(irq)
  );
  opte_enc_model i_enc (.clk_in(clk), .a_out(wa), .b_out(wb));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_in <= 1'b1;
    @(posedge clk);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk);
    addr <= a;
    rd_in <= 1'b1;
    @(posedge clk);
    rd_in <= 1'b0;
    #1;
    chk(rdata, want);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask

  initial
  begin
    {wr_in, rd_in, ksw_cw, ksw_ccw, addr, wdata, pb, fkey, card} = '0;
    {main_bat, bridge_bat, transp} = 3'h7;
    {miscompares, checked, cyc} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h28, 32'h0);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h04, {16{c[1:0]}});
      wr(8'h08, {24'h0, {4{c[1:0]}}});
      tick(2);
      flips = 0;
      odd = 0;
      last = fkey_led[0];
      repeat (32)
      begin
        tick(1);
        if (fkey_led[0] !== last)
          flips++;
        last = fkey_led[0];
        if (fkey_led !== {18{last}} || pb_led !== {2{last}})
          odd++;
      end
      chk(flips, c == 1 ? 16 : c == 2 ? 4 : 0);
      chk(odd, 32'h0);
      if (c == 0 || c == 3)
        chk(last, {31'h0, c[0]});
    end
    wr(8'h04, 32'h3);
    wr(8'h08, 32'hCC);
    tick(2);
    chk({14'h0, fkey_led}, 32'h20001);
    chk({30'h0, pb_led}, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
        wr(8'h00, 32'h1);
      @(posedge clk);
      ksw_cw <= (i % 3 == 1);
      ksw_ccw <= (i % 3 == 2);
      pb <= i[1:0];
      tick(4);
      exp = (i < 3) ? (i % 3) : ((i % 3) != 0);
      exp |= (i & 3) << 2;
      rd(8'h10, exp);
    end
    rd(8'h1C, 32'h1);
    // Wheel events stay masked at first, so the line must stay low
    i_enc.revs(5, 1'b0);
    i_enc.turn(10, 1'b0);
    tick(6);
    rd(8'h14, 32'h4);
    rd(8'h18, 32'h104);
    chk(irq, 32'h0);
    i_enc.revs(6, 1'b1);
    tick(6);
    rd(8'h14, 32'h2C04);
    rd(8'h18, 32'hFFFFFFD8);
    wr(8'h20, 32'h2);
    tick(3);
    chk(irq, 32'h1);
    rd(8'h1C, 32'h2);
    tick(3);
    chk(irq, 32'h0);
    @(posedge clk);
    main_bat <= 1'b0;
    tick(12);
    rd(8'h24, 32'h5);
    @(posedge clk);
    main_bat <= 1'b1;
    tick(6);
    rd(8'h24, 32'h4);
    @(posedge clk);
    main_bat <= 1'b0;
    tick(70);
    chk(power_off, 32'h1);
    chk(shutdown, 32'h0);
    rd(8'h24, 32'h6);
    @(posedge clk);
    main_bat <= 1'b1;
    reset();
    @(posedge clk);
    transp <= 1'b0;
    tick(8);
    chk(shutdown, 32'h0);
    @(posedge clk);
    transp <= 1'b1;
    tick(4);
    wr(8'h00, 32'h2);
    @(posedge clk);
    transp <= 1'b0;
    tick(8);
    chk(shutdown, 32'h1);
    rd(8'h24, 32'h10);
    reset();
    transp <= 1'b1;
    fkey <= 18'h20005;
    card <= 1'b1;
    tick(4);
    rd(8'h0C, 32'h20005);
    wr(8'h00, 32'hC);
    @(posedge clk);
    card <= 1'b0;
    tick(4);
    rd(8'h24, 32'h24);
    rd(8'h1C, 32'h61);
    wr(8'h00, 32'h4);
    rd(8'h24, 32'h4);
    @(posedge clk);
    bridge_bat <= 1'b0;
    main_bat <= 1'b0;
    tick(10);
    chk(power_off, 32'h1);
    chk(shutdown, 32'h1);
    end_of_test();
  end
endmodule

/* design/opte_flash.sv */
`timescale 1ns/1ps
module opte_flash #(
  parameter int unsigned SLOW_HALF_CYC = 32'd62500000,
  parameter int unsigned FAST_HALF_CYC = 32'd15625000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Flash phases
  output logic slow_out,
  output logic fast_out
);
  logic [31:0] slow_cnt;
  logic [31:0] fast_cnt;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      slow_cnt <= 32'h0;
      slow_out <= 1'b0;
    end
    else if (slow_cnt == SLOW_HALF_CYC - 32'd1)
    begin
      slow_cnt <= 32'h0;
      slow_out <= ~slow_out; // R16
    end
    else
      slow_cnt <= slow_cnt + 32'd1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fast_cnt <= 32'h0;
      fast_out <= 1'b0;
    end
    else if (fast_cnt == FAST_HALF_CYC - 32'd1)
    begin
      fast_cnt <= 32'h0;
      fast_out <= ~fast_out; // R16
    end
    else
      fast_cnt <= fast_cnt + 32'd1;
  end
endmodule

/* design/opte_params.svh */
`ifndef OPTE_PARAMS_SVH
`define OPTE_PARAMS_SVH

// Clock and timing figures
`define OPTE_CLK_HZ 64'd125000000
`define OPTE_BRIDGE_TIME_S 64'd300
`define OPTE_SLOW_HALF_MS 64'd500
`define OPTE_FAST_HALF_MS 64'd125

// Two-bit LED codes
`define OPTE_LED_OFF 2'h0
`define OPTE_LED_FAST 2'h1
`define OPTE_LED_SLOW 2'h2
`define OPTE_LED_ON 2'h3

// Key switch codes
`define OPTE_KSW_MID 2'h0
`define OPTE_KSW_CW 2'h1
`define OPTE_KSW_CCW 2'h2

// Sizes
`define OPTE_NUM_FKEYS 18
`define OPTE_NUM_PB 2
`define OPTE_ADDR_W 8
`define OPTE_NET_W 16

// Register offsets
`define OPTE_REG_CTRL 8'h00
`define OPTE_REG_FKEY_LED_LO 8'h04
`define OPTE_REG_FKEY_LED_HI 8'h08
`define OPTE_REG_KEYS 8'h0C
`define OPTE_REG_SWITCH 8'h10
`define OPTE_REG_WHEEL_CNT 8'h14
`define OPTE_REG_WHEEL_NET 8'h18
`define OPTE_REG_IRQ_STATUS 8'h1C
`define OPTE_REG_IRQ_MASK 8'h20
`define OPTE_REG_POWER 8'h24

// Control register fields
`define OPTE_CTRL_KSW_BOOL 0
`define OPTE_CTRL_LOGGED_ON 1
`define OPTE_CTRL_INTEGRATED 2
`define OPTE_CTRL_CARD_BUSY 3
`define OPTE_CTRL_RESET 4'h0

// Event bits
`define OPTE_EV_KEY 0
`define OPTE_EV_WHEEL 1
`define OPTE_EV_BRIDGE 2
`define OPTE_EV_POWER_OFF 3
`define OPTE_EV_TRANSP_LOST 4
`define OPTE_EV_CARD 5
`define OPTE_EV_CARD_ERR 6
`define OPTE_NUM_EV 7

`endif

/* design/opte_pkg.sv */
package opte_pkg;
  typedef logic [1:0] opte_led_code_t;
  typedef enum logic [1:0] {PWR_RUN, PWR_BRIDGE, PWR_OFF} opte_pwr_state_t;
endpackage

/* design/opte_top.sv */
// Operation
// R1: Each of the eighteen function keys has its own controller-driven LED.
// R2: Function key LED code: 00 off, 01 fast flash, 10 slow flash, 11 on.
// R3: Pushbutton LEDs use the same two-bit code as function key LEDs.
// R4: Handwheel net count adds forward and subtracts backward pulses.
// R5: Net count wraps at the limits of its configured width.
// R6: One handwheel revolution gives fifty pulses.
// R7: Pulses up to two hundred per second are counted without loss.
// R8: Key switch reads 00 centre, 01 clockwise stop, 10 counter-clockwise stop.
// R9: In one-bit mode the key switch reads 1 at either stop, else 0.
// R10: Each pushbutton reads 1 in bit zero while pressed; the code reads the two pushbuttons in bits 2 and 3 of the switch register.
// R11: Without main battery, bridge runs at most five minutes, then power off.
// R12: Losing the transponder while logged on triggers a shutdown.
// R13: Card may be swapped live; removal during card access is flagged.
// R14: Forward and backward pulse counts are eight-bit, wrapping 255 to 0.
// R15: Both pulse counters are zero after start-up.
// R16: Slow and fast flash rates come from prescaled counters, fast is faster.
`timescale 1ns/1ps
`include "opte_params.svh"
module opte_top #(
  parameter int NET_W = `OPTE_NET_W,
  parameter logic [39:0] BRIDGE_CYC = 40'(`OPTE_BRIDGE_TIME_S * `OPTE_CLK_HZ),
  parameter int unsigned SLOW_HALF_CYC = 32'(`OPTE_SLOW_HALF_MS * `OPTE_CLK_HZ / 64'd1000),
  parameter int unsigned FAST_HALF_CYC = 32'(`OPTE_FAST_HALF_MS * `OPTE_CLK_HZ / 64'd1000)
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Register port
  input wire logic [`OPTE_ADDR_W-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  // Operator controls
  input wire logic [`OPTE_NUM_FKEYS-1:0] FKEY_IN,
  input wire logic KSW_CW_IN,
  input wire logic KSW_CCW_IN,
  input wire logic [`OPTE_NUM_PB-1:0] PB_IN,
  input wire logic WHEEL_A_IN,
  input wire logic WHEEL_B_IN,
  // Power, range and card
  input wire logic MAIN_BAT_IN,
  input wire logic BRIDGE_BAT_IN,
  input wire logic TRANSP_SEEN_IN,
  input wire logic CARD_IN,
  // Indicators
  output logic [`OPTE_NUM_FKEYS-1:0] FKEY_LED_OUT,
  output logic [`OPTE_NUM_PB-1:0] PB_LED_OUT,
  output logic POWER_OFF_OUT,
  output logic SHUTDOWN_OUT,
  output logic IRQ_OUT
);
  localparam int NUM_LED = `OPTE_NUM_FKEYS + `OPTE_NUM_PB;
  localparam int NUM_SYNC = `OPTE_NUM_FKEYS + `OPTE_NUM_PB + 8;

  // Pin synchronisers
  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_meta;
  logic [NUM_SYNC-1:0] pin_sync;
  logic [`OPTE_NUM_FKEYS-1:0] fkey_s;
  logic [`OPTE_NUM_PB-1:0] pb_s;
  logic cw_s;
  logic ccw_s;
  logic wa_s;
  logic wb_s;
  logic main_bat_s;
  logic bridge_bat_s;
  logic transp_s;
  logic card_s;

  // Control and status state
  logic [3:0] ctrl;
  logic [2*NUM_LED-1:0] led_code;
  logic [`OPTE_NUM_EV-1:0] irq_status;
  logic [`OPTE_NUM_EV-1:0] irq_mask;
  logic [`OPTE_NUM_EV-1:0] ev;
  logic [`OPTE_NUM_FKEYS-1:0] fkey_prev;
  logic [`OPTE_NUM_PB-1:0] pb_prev;
  logic [1:0] ksw_prev;
  logic [1:0] ksw_code;
  logic transp_prev;
  logic card_prev;
  logic shut_latch;
  logic card_err;
  opte_pkg::opte_pwr_state_t pwr_state;
  opte_pkg::opte_pwr_state_t next_pwr_state;
  logic [39:0] bridge_cnt;
  logic [NUM_LED-1:0] led_drive;

  // Submodule outputs
  logic slow_ph;
  logic fast_ph;
  logic [7:0] fwd_cnt;
  logic [7:0] bwd_cnt;
  logic [NET_W-1:0] net_cnt;
  logic wheel_pulse;

  logic wr_ctrl;
  logic wr_led_lo;
  logic wr_led_hi;
  logic wr_mask;
  logic rd_status;

  assign pin_raw = {FKEY_IN, PB_IN, KSW_CW_IN, KSW_CCW_IN, WHEEL_A_IN, WHEEL_B_IN,
                    MAIN_BAT_IN, BRIDGE_BAT_IN, TRANSP_SEEN_IN, CARD_IN};

  // Not reset: pins flush through during reset, so no false battery loss follows it
  always_ff @(posedge CLK_IN)
  begin
    pin_meta <= pin_raw;
    pin_sync <= pin_meta; // R7
  end

  assign {fkey_s, pb_s, cw_s, ccw_s, wa_s, wb_s,
          main_bat_s, bridge_bat_s, transp_s, card_s} = pin_sync;

  assign wr_ctrl = WR_IN && (ADDR_IN == `OPTE_REG_CTRL);
  assign wr_led_lo = WR_IN && (ADDR_IN == `OPTE_REG_FKEY_LED_LO);
  assign wr_led_hi = WR_IN && (ADDR_IN == `OPTE_REG_FKEY_LED_HI);
  assign wr_mask = WR_IN && (ADDR_IN == `OPTE_REG_IRQ_MASK);
  assign rd_status = RD_IN && (ADDR_IN == `OPTE_REG_IRQ_STATUS);

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      ctrl <= `OPTE_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= WDATA_IN[3:0];
  end

  // Two bits per LED: keys 1 to 16 in the low word, keys 17, 18 and pushbuttons above
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      led_code <= '0;
    else if (wr_led_lo)
      led_code[31:0] <= WDATA_IN; // R1
    else if (wr_led_hi)
      led_code[2*NUM_LED-1:32] <= WDATA_IN[2*NUM_LED-33:0]; // R1 R3
  end

  opte_flash #(
    .SLOW_HALF_CYC(SLOW_HALF_CYC),
    .FAST_HALF_CYC(FAST_HALF_CYC)
  ) u_flash (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .slow_out(slow_ph),
    .fast_out(fast_ph)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LED; gi++)
    begin : g_led
      always_ff @(posedge CLK_IN)
      begin
        if (RST_IN)
          led_drive[gi] <= 1'b0;
        else
          case (led_code[2*gi+1:2*gi]) // R2 R3
            `OPTE_LED_OFF: led_drive[gi] <= 1'b0;
            `OPTE_LED_FAST: led_drive[gi] <= fast_ph;
            `OPTE_LED_SLOW: led_drive[gi] <= slow_ph;
            `OPTE_LED_ON: led_drive[gi] <= 1'b1;
            default: led_drive[gi] <= 1'b0;
          endcase
      end
    end
  endgenerate

  assign FKEY_LED_OUT = led_drive[`OPTE_NUM_FKEYS-1:0]; // R1
  assign PB_LED_OUT = led_drive[NUM_LED-1:`OPTE_NUM_FKEYS]; // R3

  // One count per track A rising edge; 50 per turn with the fitted encoder
  opte_wheel #(
    .NET_W(NET_W)
  ) u_wheel (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .a_in(wa_s),
    .b_in(wb_s),
    .fwd_cnt_out(fwd_cnt),
    .bwd_cnt_out(bwd_cnt),
    .net_out(net_cnt),
    .pulse_out(wheel_pulse)
  ); // R6

  // Both stops at once cannot happen mechanically; clockwise wins
  always_comb
  begin
    if (ctrl[`OPTE_CTRL_KSW_BOOL])
      ksw_code = {1'b0, cw_s | ccw_s}; // R9
    else if (cw_s)
      ksw_code = `OPTE_KSW_CW; // R8
    else if (ccw_s)
      ksw_code = `OPTE_KSW_CCW; // R8
    else
      ksw_code = `OPTE_KSW_MID; // R8
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      fkey_prev <= '0;
      pb_prev <= '0;
      ksw_prev <= 2'h0;
      transp_prev <= 1'b0;
      card_prev <= 1'b0;
    end
    else
    begin
      fkey_prev <= fkey_s;
      pb_prev <= pb_s;
      ksw_prev <= ksw_code;
      transp_prev <= transp_s;
      card_prev <= card_s;
    end
  end

  // Bridge timer: the power-off decision is final until reset
  always_comb
  begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      opte_pkg::PWR_RUN:
        if (!main_bat_s)
          next_pwr_state = bridge_bat_s ? opte_pkg::PWR_BRIDGE : opte_pkg::PWR_OFF;
      opte_pkg::PWR_BRIDGE:
        if (main_bat_s)
          next_pwr_state = opte_pkg::PWR_RUN;
        else if (!bridge_bat_s || bridge_cnt == BRIDGE_CYC - 40'd1)
          next_pwr_state = opte_pkg::PWR_OFF; // R11
      opte_pkg::PWR_OFF:
        next_pwr_state = opte_pkg::PWR_OFF;
      default:
        next_pwr_state = opte_pkg::PWR_OFF;
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      pwr_state <= opte_pkg::PWR_RUN;
    else
      pwr_state <= next_pwr_state;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      bridge_cnt <= 40'h0;
    else if (pwr_state == opte_pkg::PWR_BRIDGE)
      bridge_cnt <= bridge_cnt + 40'd1; // R11
    else
      bridge_cnt <= 40'h0;
  end

  // Loss of the transponder is judged only while logged onto a range
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      shut_latch <= 1'b0;
    else if (ctrl[`OPTE_CTRL_LOGGED_ON] && transp_prev && !transp_s)
      shut_latch <= 1'b1; // R12
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      card_err <= 1'b0;
    else if (ctrl[`OPTE_CTRL_CARD_BUSY] && card_prev && !card_s)
      card_err <= 1'b1; // R13
    else if (wr_ctrl)
      card_err <= 1'b0;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      POWER_OFF_OUT <= 1'b0;
      SHUTDOWN_OUT <= 1'b0;
    end
    else
    begin
      POWER_OFF_OUT <= (next_pwr_state == opte_pkg::PWR_OFF); // R11
      SHUTDOWN_OUT <= shut_latch |
                      (ctrl[`OPTE_CTRL_INTEGRATED] && pwr_state == opte_pkg::PWR_OFF); // R11 R12
    end
  end

  always_comb
  begin
    ev = '0;
    ev[`OPTE_EV_KEY] = (fkey_s != fkey_prev) || (pb_s != pb_prev) || (ksw_code != ksw_prev);
    ev[`OPTE_EV_WHEEL] = wheel_pulse;
    ev[`OPTE_EV_BRIDGE] = (pwr_state == opte_pkg::PWR_RUN) &&
                          (next_pwr_state == opte_pkg::PWR_BRIDGE);
    ev[`OPTE_EV_POWER_OFF] = (pwr_state != opte_pkg::PWR_OFF) &&
                             (next_pwr_state == opte_pkg::PWR_OFF);
    ev[`OPTE_EV_TRANSP_LOST] = ctrl[`OPTE_CTRL_LOGGED_ON] && transp_prev && !transp_s;
    ev[`OPTE_EV_CARD] = card_s != card_prev; // R13
    ev[`OPTE_EV_CARD_ERR] = ctrl[`OPTE_CTRL_CARD_BUSY] && card_prev && !card_s;
  end

  // A new event in the cycle of the clearing read survives the clear
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      irq_status <= '0;
    else if (rd_status)
      irq_status <= ev;
    else
      irq_status <= irq_status | ev;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      irq_mask <= '0;
    else if (wr_mask)
      irq_mask <= WDATA_IN[`OPTE_NUM_EV-1:0];
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      IRQ_OUT <= 1'b0;
    else
      IRQ_OUT <= |(next_irq_status() & irq_mask);
  end

  function automatic logic [`OPTE_NUM_EV-1:0] next_irq_status();
    next_irq_status = rd_status ? ev : (irq_status | ev);
  endfunction

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      RDATA_OUT <= 32'h0;
    else if (!RD_IN)
      RDATA_OUT <= 32'h0;
    else
      case (ADDR_IN)
        `OPTE_REG_CTRL: RDATA_OUT <= {28'h0, ctrl};
        `OPTE_REG_FKEY_LED_LO: RDATA_OUT <= led_code[31:0];
        `OPTE_REG_FKEY_LED_HI: RDATA_OUT <= 32'(led_code[2*NUM_LED-1:32]);
        `OPTE_REG_KEYS: RDATA_OUT <= 32'(fkey_s);
        `OPTE_REG_SWITCH: RDATA_OUT <= {28'h0, pb_s, ksw_code}; // R8 R9 R10
        `OPTE_REG_WHEEL_CNT: RDATA_OUT <= {16'h0, bwd_cnt, fwd_cnt}; // R14
        `OPTE_REG_WHEEL_NET: RDATA_OUT <= 32'(signed'(net_cnt)); // R4 R5
        `OPTE_REG_IRQ_STATUS: RDATA_OUT <= 32'(irq_status);
        `OPTE_REG_IRQ_MASK: RDATA_OUT <= 32'(irq_mask);
        `OPTE_REG_POWER: RDATA_OUT <= {26'h0, card_err, shut_latch, card_s, transp_s,
                                       pwr_state};
        default: RDATA_OUT <= 32'h0;
      endcase
  end
endmodule

/* design/opte_wheel.sv */
`timescale 1ns/1ps
module opte_wheel #(
  parameter int NET_W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Synchronised encoder tracks
  input wire logic a_in,
  input wire logic b_in,
  // Counts
  output logic [7:0] fwd_cnt_out,
  output logic [7:0] bwd_cnt_out,
  output logic [NET_W-1:0] net_out,
  output logic pulse_out
);
  logic a_prev;
  logic step;

  // One pulse per rising edge of track A; B gives the direction
  assign step = a_in & ~a_prev;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      a_prev <= 1'b0;
    else
      a_prev <= a_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      fwd_cnt_out <= 8'h00; // R15
      bwd_cnt_out <= 8'h00; // R15
      net_out <= '0;
    end
    else if (step && !b_in)
    begin
      fwd_cnt_out <= fwd_cnt_out + 8'h01; // R14
      net_out <= net_out + NET_W'(1); // R4 R5
    end
    else if (step)
    begin
      bwd_cnt_out <= bwd_cnt_out + 8'h01; // R14
      net_out <= net_out - NET_W'(1); // R4 R5
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      pulse_out <= 1'b0;
    else
      pulse_out <= step;
  end
endmodule
